// file: pkg/vaf_pkg.sv
package vaf_pkg;
  localparam int        PIX_525     = 858;
  localparam int        PIX_625     = 864;
  localparam int        ACTIVE_PIX  = 720;
  localparam int        PIX_RATE_HZ = 13_500_000;
  localparam logic [10:0] SPL_525   = 11'(2 * PIX_525);
  localparam logic [10:0] SPL_625   = 11'(2 * PIX_625);
  localparam logic [10:0] ACT_END   = 11'(2 * ACTIVE_PIX);
  localparam logic [10:0] PKT_START = 11'(2 * ACTIVE_PIX + 4);
  localparam logic [10:0] HS_START  = 11'd1456;
  localparam logic [10:0] HS_END    = 11'd1584;
  localparam logic [9:0]  LINES_525 = 10'd525;
  localparam logic [9:0]  LINES_625 = 10'd625;
  localparam logic [9:0]  HALF_525  = 10'd263;
  localparam logic [9:0]  HALF_625  = 10'd313;
  localparam logic [9:0]  VBLANK_LINES = 10'd20;
  localparam logic [9:0]  VSYNC_LINES  = 10'd3;
  localparam logic [9:0]  VBI_FIRST = 10'd6;
  localparam logic [9:0]  VBI_LAST  = 10'd27;
  localparam logic [9:0]  HI_LINE   = 10'd24;
  localparam logic [7:0]  PRE_ZERO  = 8'h00;
  localparam logic [7:0]  PRE_ONES  = 8'hFF;
  localparam logic [7:0]  FILL_BYTE = 8'h80;
  localparam logic [7:0]  BLANK_Y   = 8'h10;
  localparam logic [7:0]  BLANK_C   = 8'h80;
  localparam logic [7:0]  DID_F1    = 8'h91;
  localparam logic [7:0]  DID_F1_HI = 8'h53;
  localparam logic [7:0]  DID_F2    = 8'h55;
  localparam logic [7:0]  DID_F2_HI = 8'h97;
  localparam logic [5:0]  RAW_DID   = 6'h10;
  localparam logic [5:0]  RAW_SDID  = 6'h0F;
  localparam logic [5:0]  RAW_COUNT = 6'h3F;
  localparam logic [6:0]  HDR_LEN   = 7'd8;
  localparam int        STORE_BYTES = 512;
  localparam int        BUF_WORDS   = 16;

  typedef enum logic [2:0] {P_IDLE, P_HDR, P_PAY, P_CSUM, P_FILL} vaf_pst_t;

  typedef struct packed {
    logic [9:0] line;
    logic       field2;
    logic [5:0] sdid;
    logic       match1;
    logic       match2;
    logic       err;
    logic [5:0] len;
  } vaf_slice_t;
endpackage : vaf_pkg

// file: rtl/vaf_fifo.sv
`timescale 1ns/1ps
module vaf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  logic [AW:0]      next_cnt;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rp];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // Flags are registered so in_ready and out_valid come straight from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp        <= '0;
      rp        <= '0;
      cnt       <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wp        <= push ? AW'(wp == AW'(DEPTH - 1) ? 0 : wp + 1'b1) : wp;
      rp        <= pop ? AW'(rp == AW'(DEPTH - 1) ? 0 : rp + 1'b1) : rp;
      cnt       <= next_cnt;
      in_ready  <= next_cnt != (AW+1)'(DEPTH);
      out_valid <= next_cnt != '0;
    end
  end
endmodule : vaf_fifo

// file: rtl/vaf_formatter.sv
`timescale 1ns/1ps
// Operation
// - Insert sliced packets into embedded-sync stream
// - Send packet in next line's blanking
// - Copy every packet into 512-byte store
// - Preamble 00 FF FF, then ID bytes
// - Identifier from field and line 24
// - Line number split over bytes 6,7
// - Match flags bits 3,2; top zero
// - Bit 4 reports corrected data error
// - Six-bit checksum identifier through payload
// - Fill 80h to four-byte multiple
// - Optional raw 2x samples as block
// - Raw block in active part, all lines
// - Select discrete-sync or embedded-code output
// - Accept slices only on lines 6-27
module vaf_formatter #(
  parameter int BUF_DEPTH   = vaf_pkg::BUF_WORDS,
  parameter int STORE_DEPTH = vaf_pkg::STORE_BYTES
) (
  input  wire logic               CLOCK,
  input  wire logic               RST,
  input  wire logic               MODE_656,
  input  wire logic               STD_625,
  input  wire logic               RAW_ENABLE,
  input  wire logic [7:0]         VIDEO_IN,
  input  wire logic [7:0]         RAW_IN,
  input  wire logic               SLICE_VALID,
  input  wire vaf_pkg::vaf_slice_t SLICE_INFO,
  input  wire logic               PAY_VALID,
  input  wire logic [7:0]         PAY_DATA,
  output logic                    PAY_READY,
  output logic                    STORE_VALID,
  input  wire logic               STORE_READY,
  output logic      [7:0]         STORE_DATA,
  output logic      [7:0]         OUT_DATA,
  output logic                    HSYNC,
  output logic                    VSYNC,
  output logic                    AVID,
  output logic                    FIELD,
  output logic                    PKT_ACTIVE,
  output logic                    STORE_OVERFLOW
);
  logic [10:0]         hc;
  logic [9:0]          vc;
  logic [10:0]         spl;
  logic [9:0]          lpf;
  logic [9:0]          half;
  logic                field2;
  logic [9:0]          fline;
  logic                vblank;
  logic                active;
  logic                pend;
  logic [9:0]          pend_vc;
  vaf_pkg::vaf_slice_t info;
  vaf_pkg::vaf_pst_t   pst;
  logic [6:0]          pos;
  logic [5:0]          csum;
  logic [6:0]          tot;
  logic [6:0]          tot4;
  logic [5:0]          wc;
  logic [7:0]          did;
  logic [7:0]          pkt_byte;
  logic                emit;
  logic                start;
  logic                capture;
  logic                buf_valid;
  logic [7:0]          buf_data;
  logic                store_ready_in;
  logic [7:0]          next_out;
  logic [10:0]         k;

  function automatic logic [7:0] par_byte(input logic [5:0] d);
    par_byte = {~(^d), ^d, d};
  endfunction : par_byte

  function automatic logic [7:0] sync_word(input logic f, input logic v, input logic h);
    sync_word = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction : sync_word

  assign spl    = STD_625 ? vaf_pkg::SPL_625 : vaf_pkg::SPL_525;
  assign lpf    = STD_625 ? vaf_pkg::LINES_625 : vaf_pkg::LINES_525;
  assign half   = STD_625 ? vaf_pkg::HALF_625 : vaf_pkg::HALF_525;
  assign field2 = vc >= half;
  assign fline  = field2 ? 10'(vc - half) : vc;
  assign vblank = fline < vaf_pkg::VBLANK_LINES;
  assign active = hc < vaf_pkg::ACT_END;

  // Sample counter, two bytes per pixel
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      hc <= '0;
    end else begin
      hc <= (hc >= spl - 11'd1) ? 11'd0 : 11'(hc + 11'd1);
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      vc <= '0;
    end else if (hc >= spl - 11'd1) begin
      vc <= (vc >= lpf - 10'd1) ? 10'd0 : 10'(vc + 10'd1);
    end
  end

  // Discrete sync outputs, kept in both modes
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      HSYNC <= 1'b0;
      VSYNC <= 1'b0;
      AVID  <= 1'b0;
      FIELD <= 1'b0;
    end else begin
      HSYNC <= hc >= vaf_pkg::HS_START && hc < vaf_pkg::HS_END;
      VSYNC <= fline < vaf_pkg::VSYNC_LINES;
      AVID  <= active && !vblank;
      FIELD <= field2;
    end
  end

  assign capture = SLICE_VALID && !pend && pst == vaf_pkg::P_IDLE
                   && SLICE_INFO.line >= vaf_pkg::VBI_FIRST && SLICE_INFO.line <= vaf_pkg::VBI_LAST;
  // Start after EAV of a later line
  assign start = pend && pst == vaf_pkg::P_IDLE && hc == vaf_pkg::PKT_START
                 && vc != pend_vc;

  // One slot only; a slice arriving while one waits or is sent is dropped
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pend    <= 1'b0;
      pend_vc <= '0;
      info    <= '0;
    end else if (start) begin
      pend <= 1'b0;
    end else if (capture) begin
      pend    <= 1'b1;
      pend_vc <= vc;
      info    <= SLICE_INFO;
    end
  end

  // Length rounded up to whole words
  always_comb begin
    tot  = 7'(vaf_pkg::HDR_LEN + 7'd1 + {1'b0, info.len});
    tot4 = 7'(tot + 7'd3) & 7'h7C;
    wc   = 6'(tot4[6:2] - 5'd2);
  end

  always_comb begin
    if (info.field2) begin
      did = (info.line >= vaf_pkg::HI_LINE) ? vaf_pkg::DID_F2_HI : vaf_pkg::DID_F2;
    end else begin
      did = (info.line >= vaf_pkg::HI_LINE) ? vaf_pkg::DID_F1_HI : vaf_pkg::DID_F1;
    end
  end

  always_comb begin
    pkt_byte = vaf_pkg::FILL_BYTE;
    unique case (pst)
      vaf_pkg::P_IDLE: pkt_byte = vaf_pkg::FILL_BYTE;
      vaf_pkg::P_HDR: begin
        unique case (pos[2:0])
          3'd0: pkt_byte = vaf_pkg::PRE_ZERO;
          3'd1: pkt_byte = vaf_pkg::PRE_ONES;
          3'd2: pkt_byte = vaf_pkg::PRE_ONES;
          3'd3: pkt_byte = par_byte(did[5:0]);
          3'd4: pkt_byte = par_byte(info.sdid);
          3'd5: pkt_byte = par_byte(wc);
          3'd6: pkt_byte = info.line[7:0];
          3'd7: pkt_byte = {3'b000, info.err, info.match1, info.match2, info.line[9:8]};
        endcase
      end
      vaf_pkg::P_PAY:  pkt_byte = buf_data;
      vaf_pkg::P_CSUM: pkt_byte = {2'b00, csum};
      vaf_pkg::P_FILL: pkt_byte = vaf_pkg::FILL_BYTE;
    endcase
  end

  // An empty payload buffer holds the packet; the source must stay ahead
  assign emit = pst != vaf_pkg::P_IDLE && !(pst == vaf_pkg::P_PAY && !buf_valid);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pst <= vaf_pkg::P_IDLE;
      pos <= '0;
    end else begin
      unique case (pst)
        vaf_pkg::P_IDLE: begin
          pos <= '0;
          pst <= start ? vaf_pkg::P_HDR : vaf_pkg::P_IDLE;
        end
        vaf_pkg::P_HDR: begin
          pos <= 7'(pos + 7'd1);
          if (pos == 7'd7) begin
            pst <= (info.len == '0) ? vaf_pkg::P_CSUM : vaf_pkg::P_PAY;
          end
        end
        vaf_pkg::P_PAY: begin
          if (emit) begin
            pos <= 7'(pos + 7'd1);
            if (pos == 7'(7'd7 + {1'b0, info.len})) begin
              pst <= vaf_pkg::P_CSUM;
            end
          end
        end
        vaf_pkg::P_CSUM, vaf_pkg::P_FILL: begin
          pos <= 7'(pos + 7'd1);
          pst <= (7'(pos + 7'd1) == tot4) ? vaf_pkg::P_IDLE : vaf_pkg::P_FILL;
        end
      endcase
    end
  end

  // Sum identifier through last payload byte
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      csum <= '0;
    end else if (start) begin
      csum <= '0;
    end else if (emit && pos >= 7'd3
                 && (pst == vaf_pkg::P_HDR || pst == vaf_pkg::P_PAY)) begin
      csum <= 6'(csum + pkt_byte[5:0]);
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PKT_ACTIVE     <= 1'b0;
      STORE_OVERFLOW <= 1'b0;
    end else begin
      PKT_ACTIVE     <= emit;
      STORE_OVERFLOW <= STORE_OVERFLOW || (emit && !store_ready_in);
    end
  end

  // Back-pressure on the slicer payload path
  vaf_fifo #(
    .WIDTH (8),
    .DEPTH (BUF_DEPTH)
  ) u_pay_buf (
    .clk       (CLOCK),
    .rst       (RST),
    .in_valid  (PAY_VALID),
    .in_ready  (PAY_READY),
    .in_data   (PAY_DATA),
    .out_valid (buf_valid),
    .out_ready (pst == vaf_pkg::P_PAY),
    .out_data  (buf_data)
  );

  // Store copy of each packet byte
  vaf_fifo #(
    .WIDTH (8),
    .DEPTH (STORE_DEPTH)
  ) u_store (
    .clk       (CLOCK),
    .rst       (RST),
    .in_valid  (emit),
    .in_ready  (store_ready_in),
    .in_data   (pkt_byte),
    .out_valid (STORE_VALID),
    .out_ready (STORE_READY),
    .out_data  (STORE_DATA)
  );

  assign k = 11'(hc - vaf_pkg::ACT_END);

  always_comb begin
    next_out = hc[0] ? vaf_pkg::BLANK_Y : vaf_pkg::BLANK_C;
    if (!MODE_656) begin
      if (active && !vblank) begin
        next_out = VIDEO_IN;
      end
    end else if (hc >= vaf_pkg::ACT_END && hc < vaf_pkg::PKT_START) begin
      next_out = (k == 11'd0) ? vaf_pkg::PRE_ONES
               : (k == 11'd3) ? sync_word(field2, vblank, 1'b1) : vaf_pkg::PRE_ZERO;
    end else if (hc >= spl - 11'd4) begin
      next_out = (hc == spl - 11'd4) ? vaf_pkg::PRE_ONES
               : (hc == spl - 11'd1) ? sync_word(field2, vblank, 1'b0) : vaf_pkg::PRE_ZERO;
    end else if (emit) begin
      next_out = pkt_byte;
    end else if (active && RAW_ENABLE) begin
      unique case (hc)
        11'd0:   next_out = vaf_pkg::PRE_ZERO;
        11'd1:   next_out = vaf_pkg::PRE_ONES;
        11'd2:   next_out = vaf_pkg::PRE_ONES;
        11'd3:   next_out = par_byte(vaf_pkg::RAW_DID);
        11'd4:   next_out = par_byte(vaf_pkg::RAW_SDID);
        11'd5:   next_out = par_byte(vaf_pkg::RAW_COUNT);
        default: next_out = RAW_IN;
      endcase
    end else if (active && !vblank) begin
      next_out = VIDEO_IN;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      OUT_DATA <= vaf_pkg::BLANK_C;
    end else begin
      OUT_DATA <= next_out;
    end
  end

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_preamble;
    OUT_DATA == 8'h00 ##1 OUT_DATA == 8'hFF ##1 OUT_DATA == 8'hFF;
  endsequence

  sequence s_eav;
    OUT_DATA == 8'hFF ##1 OUT_DATA == 8'h00 ##1 OUT_DATA == 8'h00 ##1 OUT_DATA[4];
  endsequence

  a_pkt_preamble: assert property (
    (MODE_656 && pst == vaf_pkg::P_HDR && pos == 7'd0) |=> s_preamble)
    else $error("packet preamble wrong");

  a_pkt_in_blank: assert property (
    (pst != vaf_pkg::P_IDLE) |-> !active)
    else $error("packet outside horizontal blanking");

  a_start_later: assert property (
    $rose(pst == vaf_pkg::P_HDR) |-> $past(vc) != pend_vc)
    else $error("packet sent on its own slice line");

  a_eav_code: assert property (
    (MODE_656 && hc == vaf_pkg::ACT_END) |=> s_eav)
    else $error("timing reference code wrong");

  a_did_value: assert property (
    (MODE_656 && pst == vaf_pkg::P_HDR && pos == 7'd3) |=> OUT_DATA == did)
    else $error("identifier byte wrong");

  a_parity_bits: assert property (
    (MODE_656 && pst == vaf_pkg::P_HDR && pos >= 7'd3 && pos <= 7'd5)
    |=> (OUT_DATA[6] == ^OUT_DATA[5:0]) && (OUT_DATA[7] != OUT_DATA[6]))
    else $error("parity bits wrong");

  a_flag_byte: assert property (
    (MODE_656 && pst == vaf_pkg::P_HDR && pos == 7'd7)
    |=> OUT_DATA == {3'b000, info.err, info.match1, info.match2, info.line[9:8]})
    else $error("flag byte wrong");

  a_fill_align: assert property (
    (pst != vaf_pkg::P_IDLE && pst != vaf_pkg::P_PAY) ##1 (pst == vaf_pkg::P_IDLE)
    |-> pos[1:0] == 2'b00)
    else $error("packet not a multiple of four");

  a_line_range: assert property (
    $rose(pend) |-> info.line >= 10'd6 && info.line <= 10'd27)
    else $error("slice accepted outside service lines");

  a_raw_header: assert property (
    (MODE_656 && RAW_ENABLE && hc == 11'd0) |=> s_preamble)
    else $error("raw block header wrong");
endmodule : vaf_formatter

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                CLOCK, RST, MODE_656, STD_625, RAW_ENABLE;
  logic [7:0]          VIDEO_IN, RAW_IN, PAY_DATA, STORE_DATA, OUT_DATA;
  logic                SLICE_VALID, PAY_VALID, PAY_READY, STORE_VALID, STORE_READY;
  logic                HSYNC, VSYNC, AVID, FIELD, PKT_ACTIVE, STORE_OVERFLOW;
  vaf_pkg::vaf_slice_t SLICE_INFO, s;
  int                  mismatches, num_checks, cyc, n_hi, n_bad;
  logic [31:0]         rs, sh, exp_w;
  logic [7:0]          exp_q[$];
  logic [7:0]          pay_q[$];
  logic [9:0]          lines_c[4] = '{10'd24, 10'd23, 10'd6, 10'd27};
  longint              t0, t1, t2;

  vaf_formatter dut_u (.CLOCK(CLOCK), .RST(RST), .MODE_656(MODE_656), .STD_625(STD_625),
    .RAW_ENABLE(RAW_ENABLE), .VIDEO_IN(VIDEO_IN), .RAW_IN(RAW_IN), .SLICE_VALID(SLICE_VALID),
    .SLICE_INFO(SLICE_INFO), .PAY_VALID(PAY_VALID), .PAY_DATA(PAY_DATA), .PAY_READY(PAY_READY),
    .STORE_VALID(STORE_VALID), .STORE_READY(STORE_READY), .STORE_DATA(STORE_DATA),
    .OUT_DATA(OUT_DATA), .HSYNC(HSYNC), .VSYNC(VSYNC), .AVID(AVID), .FIELD(FIELD),
    .PKT_ACTIVE(PKT_ACTIVE), .STORE_OVERFLOW(STORE_OVERFLOW));
  vaf_capture cap_u (.CLOCK(CLOCK), .RST(RST), .OUT_DATA(OUT_DATA), .PKT_ACTIVE(PKT_ACTIVE),
    .STORE_VALID(STORE_VALID), .STORE_DATA(STORE_DATA), .STORE_READY(STORE_READY));

  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) VIDEO_IN <= #1 VIDEO_IN + 8'h01;
  always @(posedge CLOCK) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      mismatches = mismatches + 1;
      $display("BAD %0t run did not finish", $time);
      test_done();
    end
  end

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  function automatic logic [7:0] par(input logic [5:0] v);
    return {~(^v), ^v, v};
  endfunction : par

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : tick
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Builds the whole packet the receiver should see for one slice
  task automatic make_exp(input vaf_pkg::vaf_slice_t si);
    int         tot;
    logic [7:0] sum;
    exp_q = {8'h00, 8'hFF, 8'hFF};
    if (si.field2) exp_q.push_back(si.line >= 10'd24 ? 8'h97 : 8'h55);
    else exp_q.push_back(si.line >= 10'd24 ? 8'h53 : 8'h91);
    tot = ((9 + si.len + 3) / 4) * 4;
    exp_q.push_back(par(si.sdid));
    exp_q.push_back(par(6'(tot / 4 - 2)));
    exp_q.push_back(si.line[7:0]);
    exp_q.push_back({3'b000, si.err, si.match1, si.match2, si.line[9:8]});
    foreach (pay_q[i]) exp_q.push_back(pay_q[i]);
    sum = 8'h00;
    for (int i = 3; i < exp_q.size(); i++) sum = sum + exp_q[i];
    exp_q.push_back({2'b00, sum[5:0]});
    while (exp_q.size() < tot) exp_q.push_back(8'h80);
  endtask : make_exp

  // Pushes up to n payload bytes; gives up after n+8 cycles while the buffer refuses
  task automatic push_pay(input int n);
    pay_q.delete();
    PAY_VALID = 1'b1;
    PAY_DATA = 8'(rnd());
    for (int c = 0; c < n + 8 && pay_q.size() < n; c++) begin
      @(posedge CLOCK);
      if (PAY_READY === 1'b1) pay_q.push_back(PAY_DATA);
      #1;
      PAY_DATA = 8'(rnd());
    end
    PAY_VALID = 1'b0;
  endtask : push_pay

  // kind 0: slice refused, 1: normal, 2: second slice while one is pending
  task automatic send_pkt(input vaf_pkg::vaf_slice_t si, input int kind);
    int     w;
    longint lim;
    cap_u.strm_q.delete();
    cap_u.store_q.delete();
    make_exp(si);
    SLICE_INFO = si;
    SLICE_VALID = 1'b1;
    lim = $time + (STD_625 ? 1728 : 1716) * 20;
    tick(1);
    SLICE_INFO.line = 10'd7;
    SLICE_VALID = (kind == 2);
    tick(1);
    SLICE_VALID = 1'b0;
    w = 0;
    while (cap_u.store_q.size() < exp_q.size() && w < 4000) begin
      tick(1);
      w = w + 1;
    end
    if (kind == 0) check(cap_u.store_q.size(), 0);
    else begin
      check(cap_u.store_q.size(), exp_q.size());
      foreach (exp_q[i]) begin
        check(cap_u.store_q[i], exp_q[i]);
      end
      if (MODE_656) begin
        check(cap_u.strm_q.size(), exp_q.size());
        foreach (exp_q[i]) check(cap_u.strm_q[i], exp_q[i]);
        check((cap_u.first_t <= lim) ? 1 : 0, 1);
      end
    end
  endtask : send_pkt

  task automatic wait_hs(input logic v);
    int w;
    w = 0;
    while (HSYNC !== v && w < 4000) begin
      @(posedge CLOCK);
      w = w + 1;
    end
  endtask : wait_hs

  initial begin
    rs = 32'h5065;
    mismatches = 0;
    num_checks = 0;
    cyc = 0;
    RST = 1'b1;
    {MODE_656, STD_625, RAW_ENABLE} = 3'b100;
    {VIDEO_IN, RAW_IN, PAY_DATA} = '0;
    {SLICE_VALID, PAY_VALID} = 2'b00;
    SLICE_INFO = '0;
    tick(4);
    RST = 1'b0;
    tick(2);
    for (int i = 0; i < 6; i++) begin
      s = 26'(rnd());
      s.line = 10'(6 + rnd() % 22);
      if (i < 4) s.line = lines_c[i];
      if (i < 4) s.field2 = i[0];
      push_pay(i == 0 ? 20 : (i == 1 ? 3 : int'(rnd() % 17)));
      tick(2);
      if (i == 0) check(PAY_READY, 0);
      s.len = 6'(pay_q.size());
      send_pkt(s, i == 1 ? 2 : 1);
    end
    $display("packet tests done");
    foreach (lines_c[i]) lines_c[i] = (i == 0) ? 10'd5 : 10'd28;
    for (int i = 0; i < 2; i++) begin
      s.line = lines_c[i];
      pay_q.delete();
      s.len = 6'd0;
      send_pkt(s, 0);
    end
    $display("refusal tests done");
    // Mode changes well away from the timing codes, so no code is cut in half
    wait_hs(1);
    tick(1);
    MODE_656 = 1'b0;
    push_pay(5);
    s.line = 10'd9;
    s.len = 6'd5;
    send_pkt(s, 1);
    for (int k = 0; k < 2; k++) begin
      STD_625 = k[0];
      wait_hs(1);
      wait_hs(0);
      wait_hs(1);
      t0 = $time;
      wait_hs(0);
      t1 = $time;
      wait_hs(1);
      t2 = $time;
      #1;
      check(AVID, 0);
      check((t1 - t0) / 10, vaf_pkg::HS_END - vaf_pkg::HS_START);
      check((t2 - t0) / 10, k ? vaf_pkg::SPL_625 : vaf_pkg::SPL_525);
    end
    $display("discrete sync tests done");
    {MODE_656, RAW_ENABLE} = 2'b11;
    RAW_IN = 8'h5A;
    sh = '0;
    for (int c = 0; c < 4000 && sh[23:0] != 24'h00_FFFF; c++) begin
      @(posedge CLOCK);
      sh = {sh[23:0], OUT_DATA};
    end
    repeat (4) begin
      @(posedge CLOCK);
      sh = {sh[23:0], OUT_DATA};
    end
    exp_w = {par(vaf_pkg::RAW_DID), par(vaf_pkg::RAW_SDID), par(vaf_pkg::RAW_COUNT), RAW_IN};
    check(sh, exp_w);
    $display("raw block test done");
    check(STORE_OVERFLOW, 0);
    // Second reset in mid-run: blank output, then three sync lines with no video
    tick(1);
    RST = 1'b1;
    tick(2);
    check(OUT_DATA, vaf_pkg::BLANK_C);
    check({PAY_READY, STORE_VALID, PKT_ACTIVE}, 0);
    RST = 1'b0;
    tick(1);
    n_hi = 0;
    n_bad = 0;
    while (VSYNC === 1'b1 && n_hi < 6000) begin
      if (AVID !== 1'b0 || FIELD !== 1'b0) n_bad = n_bad + 1;
      n_hi = n_hi + 1;
      tick(1);
    end
    check(n_hi, int'(vaf_pkg::VSYNC_LINES) * int'(vaf_pkg::SPL_625));
    check(n_bad, 0);
    $display("reset test done");
    test_done();
  end
endmodule : tb_top

// file: sim/vaf_capture.sv
`timescale 1ns/1ps
module vaf_capture #(
  parameter logic [31:0] SEED = 32'h0000_1d2b
) (
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic [7:0] OUT_DATA,
  input  wire logic       PKT_ACTIVE,
  input  wire logic       STORE_VALID,
  input  wire logic [7:0] STORE_DATA,
  output logic            STORE_READY
);
  logic [7:0]  strm_q[$];
  logic [7:0]  store_q[$];
  longint      first_t;
  logic [31:0] st;
  initial begin
    STORE_READY = 1'b0;
    st = SEED;
    first_t = 0;
  end
  // Stream side keeps only bytes flagged as packet bytes
  always @(posedge CLOCK) begin
    if (!RST && PKT_ACTIVE === 1'b1) begin
      if (strm_q.size() == 0) first_t = $time;
      strm_q.push_back(OUT_DATA);
    end
  end
  // Reader stalls one cycle in four, so the store must really hold bytes
  always @(posedge CLOCK) begin
    if (!RST && STORE_VALID === 1'b1 && STORE_READY === 1'b1) store_q.push_back(STORE_DATA);
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    STORE_READY <= #1 !RST && (st[1:0] != 2'b00);
  end
endmodule : vaf_capture
